// >>> inc/wake_seq_defs.svh
// Timing and threshold constants for the wake sequencer
`ifndef WAKE_SEQ_DEFS_SVH
`define WAKE_SEQ_DEFS_SVH
`define CLOCK_MHZ 250
`define SOFT_START_US 1000
`define SOFT_START_CYCLES (`SOFT_START_US * `CLOCK_MHZ)
`define SHALLOW_DELAY_US 60
`define SHALLOW_DELAY_CYCLES (`SHALLOW_DELAY_US * `CLOCK_MHZ)
`define WAKE_PERIODS 3
`define UV_RETRY_LIMIT 3
`define UV_TRIP_MV 2475
`define UV_NOMINAL_MV 3300
`endif

// >>> inc/wake_seq_pkg.sv
// Types for the wake sequencer
package wake_seq_pkg;
  typedef enum logic [2:0] {
    ST_DEEP,
    ST_SHALLOW,
    ST_ENTER_SHALLOW,
    ST_WAKE_WAIT,
    ST_ACTIVE
  } power_state_type;

  typedef enum logic [1:0] {
    REG_RAMP,
    REG_ON,
    REG_OFF_WAIT,
    REG_LATCHED
  } regulator_state_type;

  typedef struct packed {
    logic shallow_sleep_request_n;
    logic deep_sleep_request_n;
    logic rail_12v_up;
    logic aux_undervoltage;
  } monitor_in_type;

  typedef struct packed {
    logic n_switch_gate_drive_o;
    logic n_switch_gate_drive_oe;
    logic p_switch_gate_drive_o;
    logic p_switch_gate_drive_oe;
    logic regulator_enable;
    logic regulator_standby;
    logic regulator_latched_off;
  } drive_out_type;

  typedef struct packed {
    power_state_type power;
    regulator_state_type reg_state;
    logic [31:0] timer;
    logic [31:0] reg_timer;
    logic [1:0] periods;
    logic [1:0] retries;
    drive_out_type drive;
  } seq_state_type;
endpackage : wake_seq_pkg

// >>> src/wake_sequence_uv_retry.sv
// Sleep/wake sequencer with auxiliary regulator undervoltage retry
`timescale 1ns/1ps
`include "wake_seq_defs.svh"
// Operation
// RULE_01: After 12V rail is up, wait exactly three soft-start periods, then switch over.
// RULE_02: At switchover release the N-switch gate drive to high impedance.
// RULE_03: Same cycle, actively drive the P-switch gate high.
// RULE_04: Same cycle, put the auxiliary 3.3V regulator into standby.
// RULE_05: The system enables ATX supplies on entering active; we watch the 12V monitor.
// RULE_06: Undervoltage honoured only in sleep and after the initial soft-start ramp.
// RULE_07: Undervoltage comparator trips at 25% below nominal, 2.475V.
// RULE_08: On undervoltage disable regulator, retry with soft-start after one interval.
// RULE_09: Fourth undervoltage after three retries latches regulator off until power-on reset.
// RULE_10: Overcurrent has no own path; it surfaces as undervoltage.
// RULE_11: Refuse direct transition from deep sleep to shallow sleep.
// RULE_12: Active to shallow sleep entry is delayed 60 microseconds.
// RULE_13: Active to deep sleep entry is immediate.
// RULE_14: Never enter active until the 12V rail monitor reports up.
// RULE_15: One soft-start period is a fixed clock count, shared by wake and retry.
// RULE_16: Sleep request during the wake wait abandons switchover, outputs unchanged. A deep request during a wake begun in shallow still drives the P gate high.
module wake_sequence_uv_retry import wake_seq_pkg::*; #(
  parameter int unsigned SOFT_START_CYCLES = `SOFT_START_CYCLES,
  parameter int unsigned SHALLOW_DELAY_CYCLES = `SHALLOW_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire monitor_in_type monitor,
  output drive_out_type drive
);

  // Counters stop at the last index, so one period is exactly N clocks [RULE_15]
  localparam logic [31:0] SS_LAST = 32'(SOFT_START_CYCLES - 1);
  localparam logic [31:0] SHALLOW_LAST = 32'(SHALLOW_DELAY_CYCLES - 1);
  localparam logic [1:0] WAKE_LAST = 2'(`WAKE_PERIODS - 1);
  // Retry count never passes the limit; only reset clears it
  localparam logic [1:0] RETRY_LIMIT = 2'(`UV_RETRY_LIMIT);

  seq_state_type state_reg;
  seq_state_type state_next;

  logic want_active;
  logic want_deep;
  logic want_shallow;
  logic want_hold;
  logic from_deep;
  logic sleeping;

  // Comparator is analog, set at UV_TRIP_MV; only its flag enters here [RULE_07] [RULE_10]
  always_comb begin
    want_active = monitor.shallow_sleep_request_n && monitor.deep_sleep_request_n;
    want_deep = !monitor.deep_sleep_request_n && !monitor.shallow_sleep_request_n;
    want_shallow = monitor.deep_sleep_request_n && !monitor.shallow_sleep_request_n;
    // Deep request alone is not a legal code; every state but wake wait simply holds, wake wait abandons
    want_hold = !monitor.deep_sleep_request_n && monitor.shallow_sleep_request_n;
    // P switch is off in deep sleep and on in shallow sleep, so it remembers where a wake began
    from_deep = state_reg.drive.p_switch_gate_drive_o;
    state_next = state_reg;
    case (state_reg.power)
      ST_DEEP: begin
        if (want_active && monitor.rail_12v_up) begin // [RULE_14] [RULE_05]
          state_next.power = ST_WAKE_WAIT;
          state_next.timer = '0;
          state_next.periods = '0;
        end else if (want_shallow || want_hold) begin
          // Shallow request from deep is refused; stay in deep [RULE_11]
          state_next.power = ST_DEEP;
        end
      end

      ST_SHALLOW: begin
        if (want_deep) begin
          state_next.power = ST_DEEP;
        end else if (want_active && monitor.rail_12v_up) begin // [RULE_14]
          state_next.power = ST_WAKE_WAIT;
          state_next.timer = '0;
          state_next.periods = '0;
        end else if (want_hold) begin
          state_next.power = ST_SHALLOW;
        end
      end

      ST_WAKE_WAIT: begin
        if (!want_active || !monitor.rail_12v_up) begin
          // Abandon; a deep request goes to deep, else back where the wake began; N gate untouched [RULE_16]
          if (want_deep || from_deep) begin
            state_next.power = ST_DEEP; // [RULE_11]
          end else begin
            state_next.power = ST_SHALLOW;
          end
        end else if (state_reg.timer == SS_LAST) begin // [RULE_15]
          state_next.timer = '0;
          // All three switchover actions land on the same edge
          if (state_reg.periods == WAKE_LAST) begin // [RULE_01]
            state_next.power = ST_ACTIVE;
            state_next.drive.n_switch_gate_drive_oe = 1'b0; // [RULE_02]
            state_next.drive.p_switch_gate_drive_o = 1'b1; // [RULE_03]
            state_next.drive.p_switch_gate_drive_oe = 1'b1;
            state_next.drive.regulator_standby = 1'b1; // [RULE_04]
          end else begin
            state_next.periods = state_reg.periods + 2'(1);
          end
        end else begin
          state_next.timer = state_reg.timer + 32'(1);
        end
      end

      ST_ACTIVE: begin
        if (want_deep) begin // [RULE_13]
          state_next.power = ST_DEEP;
        end else if (want_shallow) begin
          state_next.power = ST_ENTER_SHALLOW;
          state_next.timer = '0;
        end
      end

      ST_ENTER_SHALLOW: begin
        if (want_deep) begin
          state_next.power = ST_DEEP;
        end else if (want_active) begin
          state_next.power = ST_ACTIVE;
        end else if (want_hold) begin
          // Illegal code freezes the delay rather than finishing it
          state_next.timer = state_reg.timer;
        end else if (state_reg.timer == SHALLOW_LAST) begin // [RULE_12]
          state_next.power = ST_SHALLOW;
        end else begin
          state_next.timer = state_reg.timer + 32'(1);
        end
      end
      default: state_next.power = ST_DEEP;
    endcase

    // Leaving active restores sleep drive: N gate pulled low, P switch on only in shallow sleep
    if ((state_reg.power == ST_ACTIVE || state_reg.power == ST_ENTER_SHALLOW)
        && (state_next.power == ST_DEEP || state_next.power == ST_SHALLOW)) begin
      state_next.drive.n_switch_gate_drive_o = 1'b0;
      state_next.drive.n_switch_gate_drive_oe = 1'b1;
      state_next.drive.regulator_standby = 1'b0;
      // Regulator sagged in standby, so unless latched it ramps again with faults masked
      state_next.reg_state = (state_reg.reg_state == REG_LATCHED) ? REG_LATCHED : REG_RAMP;
      state_next.reg_timer = '0;
    end
    // P switch feeds the 5V dual rail in shallow sleep only
    if (state_next.power == ST_SHALLOW) begin
      state_next.drive.p_switch_gate_drive_o = 1'b0;
      state_next.drive.p_switch_gate_drive_oe = 1'b1;
    end else if (state_next.power == ST_DEEP) begin
      state_next.drive.p_switch_gate_drive_o = 1'b1;
      state_next.drive.p_switch_gate_drive_oe = 1'b1;
    end

    // Regulator protection runs only while sleeping
    // Wake wait still counts as sleep: the ATX rails are not switched in yet
    sleeping = (state_reg.power == ST_DEEP || state_reg.power == ST_SHALLOW
                || state_reg.power == ST_WAKE_WAIT);
    if (sleeping) begin
      case (state_reg.reg_state)
        REG_RAMP: begin
          // Undervoltage masked during ramp [RULE_06]
          if (state_reg.reg_timer == SS_LAST) begin
            state_next.reg_state = REG_ON;
          end else begin
            state_next.reg_timer = state_reg.reg_timer + 32'(1);
          end
        end

        REG_ON: begin
          // Each fault spends one retry; the fourth one latches
          if (monitor.aux_undervoltage) begin // [RULE_06]
            state_next.reg_timer = '0;
            state_next.drive.regulator_enable = 1'b0; // [RULE_08]
            if (state_reg.retries == RETRY_LIMIT) begin // [RULE_09]
              state_next.reg_state = REG_LATCHED;
              state_next.drive.regulator_latched_off = 1'b1;
            end else begin
              state_next.reg_state = REG_OFF_WAIT;
              state_next.retries = state_reg.retries + 2'(1);
            end
          end
        end

        REG_OFF_WAIT: begin
          // Stays off one full soft-start period before the retry
          if (state_reg.reg_timer == SS_LAST) begin // [RULE_08] [RULE_15]
            state_next.reg_state = REG_RAMP;
            state_next.reg_timer = '0;
            state_next.drive.regulator_enable = 1'b1;
          end else begin
            state_next.reg_timer = state_reg.reg_timer + 32'(1);
          end
        end

        default: state_next.drive.regulator_enable = 1'b0; // Only reset clears [RULE_09]
      endcase
    end
  end

  // Reset doubles as power-on reset; it alone clears the latch [RULE_09]
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg.power <= ST_DEEP;
      // Regulator comes up ramping, so faults are masked at first
      state_reg.reg_state <= REG_RAMP;
      state_reg.timer <= '0;
      state_reg.reg_timer <= '0;
      state_reg.periods <= '0;
      state_reg.retries <= '0;
      state_reg.drive.n_switch_gate_drive_o <= 1'b0;
      state_reg.drive.n_switch_gate_drive_oe <= 1'b1;
      state_reg.drive.p_switch_gate_drive_o <= 1'b1;
      state_reg.drive.p_switch_gate_drive_oe <= 1'b1;
      state_reg.drive.regulator_enable <= 1'b1;
      state_reg.drive.regulator_standby <= 1'b0;
      state_reg.drive.regulator_latched_off <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pins come straight from flops, so the gate drives never glitch
  assign drive = state_reg.drive;

endmodule : wake_sequence_uv_retry

// >>> sim/wake_seq_host.sv
// Chipset sleep requests and ATX 12V rail model
`timescale 1ns/1ps
module wake_seq_host (
  input wire logic clock,
  input wire logic [1:0] cmd,
  output logic shallow_sleep_request_n,
  output logic deep_sleep_request_n,
  output logic rail_12v_up
);
  logic [1:0] ramp_reg = 2'h0;
  // Command 0 active, 1 shallow, 2 deep
  assign shallow_sleep_request_n = cmd == 2'h0;
  assign deep_sleep_request_n = cmd != 2'h2;
  assign rail_12v_up = ramp_reg == 2'h3;
  // Supplies ramp only after the system goes active, drop at once on sleep
  always_ff @(negedge clock) begin
    if (cmd != 2'h0) ramp_reg <= 2'h0;
    else if (!rail_12v_up) ramp_reg <= ramp_reg + 2'h1;
  end
endmodule : wake_seq_host

// >>> sim/wake_sequence_uv_retry_properties.sv
// Port assertions for the wake sequencer
`timescale 1ns/1ps
module wake_sequence_uv_retry_properties import wake_seq_pkg::*; #(
  parameter int unsigned SOFT_START_CYCLES = 8,
  parameter int unsigned SHALLOW_DELAY_CYCLES = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire monitor_in_type monitor,
  input wire drive_out_type drive
);
  localparam int WAKE_N = 3 * SOFT_START_CYCLES + 1;
  wire oe = drive.n_switch_gate_drive_oe;
  wire p = drive.p_switch_gate_drive_o;
  wire en = drive.regulator_enable;
  wire lat = drive.regulator_latched_off;
  wire poe = drive.p_switch_gate_drive_oe;
  wire stb = drive.regulator_standby;
  wire sl = monitor.shallow_sleep_request_n;
  wire dp = monitor.deep_sleep_request_n;
  logic [31:0] wake_cnt_reg;
  always_ff @(posedge clock) begin
    if (!rst_n || !(sl && dp && monitor.rail_12v_up)) wake_cnt_reg <= 32'h0;
    else wake_cnt_reg <= wake_cnt_reg + 32'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_switch_together: assert property ($fell(oe) |-> p && poe && stb)
    else $error("switchover split");
  a_wake_not_early: assert property ($fell(oe) |-> wake_cnt_reg == WAKE_N)
    else $error("wake early");
  a_wake_not_late: assert property (wake_cnt_reg == WAKE_N |-> !oe)
    else $error("wake late");
  a_deep_immediate: assert property (!oe && !dp && !sl |=> oe)
    else $error("deep delayed");
  // Repeat counts assume the short sim counts of 8 and 5
  a_shallow_late: assert property ((!oe && dp && !sl) [*6] |=> oe)
    else $error("shallow late");
  a_deep_no_shallow: assert property (oe && p |=> p)
    else $error("left deep");
  a_retry_gap: assert property (oe && $fell(en) && !lat |-> !en [*8] ##1 en)
    else $error("retry gap");
  a_latch_sticky: assert property (lat |=> lat && !en)
    else $error("latch lost");
endmodule : wake_sequence_uv_retry_properties
bind wake_sequence_uv_retry wake_sequence_uv_retry_properties #(.SOFT_START_CYCLES(SOFT_START_CYCLES),
  .SHALLOW_DELAY_CYCLES(SHALLOW_DELAY_CYCLES)) chk (.clock(clock), .rst_n(rst_n), .monitor(monitor), .drive(drive));

// >>> sim/tb_wake_sequence_uv_retry.sv
// Self-checking bench for the wake sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t %h %h", $time, a, e); end end
module tb_wake_sequence_uv_retry import wake_seq_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic uv = 1'b0;
  logic [1:0] cmd = 2'h2;
  int errors = 0;
  int comparisons = 0;
  wire logic sl_n, dp_n, rail;
  drive_out_type drive;
  wire monitor_in_type monitor = {sl_n, dp_n, rail, uv};
  wire logic [3:0] outs = {drive.n_switch_gate_drive_oe, drive.p_switch_gate_drive_o,
    drive.regulator_standby, drive.regulator_latched_off};
  // Rows: command, edges to wait, expected gate, standby and latch outputs
  logic [15:0] rows [8] = '{16'h20CC, 16'h128C, 16'h014C, 16'h00F6, 16'h1036, 16'h1068, 16'h0236, 16'h201C};
  wake_seq_host host (.clock(clock), .cmd(cmd), .shallow_sleep_request_n(sl_n),
    .deep_sleep_request_n(dp_n), .rail_12v_up(rail));
  wake_sequence_uv_retry #(.SOFT_START_CYCLES(8), .SHALLOW_DELAY_CYCLES(5)) dut (.clock(clock),
    .rst_n(rst_n), .monitor(monitor), .drive(drive));
  initial forever #2 clock = ~clock;
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic pulse_uv();
    uv <= 1'b1;
    @(negedge clock);
    uv <= 1'b0;
  endtask : pulse_uv
  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      cmd <= rows[i][13:12];
      repeat (rows[i][11:4]) @(negedge clock);
      `CHK(outs, rows[i][3:0])
    end
    cmd <= 2'h0;
    repeat (12) @(negedge clock);
    cmd <= 2'h1;
    repeat (40) @(negedge clock);
    `CHK(outs, 4'hC)
    for (int i = 0; i < 4; i++) begin
      pulse_uv();
      repeat (2) @(negedge clock);
      `CHK({drive.regulator_enable, drive.regulator_latched_off}, {1'b0, i == 3})
      repeat (8) @(negedge clock);
      `CHK(drive.regulator_enable, i < 3)
      // On the first three passes lands inside the retry ramp, so an early count would latch too soon
      pulse_uv();
      repeat (12) @(negedge clock);
    end
    rst_n <= 1'b0;
    repeat (3) @(negedge clock);
    rst_n <= 1'b1;
    `CHK(outs, 4'hC)
    cmd <= 2'h0;
    repeat (40) @(negedge clock);
    uv <= 1'b1;
    repeat (70) @(negedge clock);
    `CHK(outs, 4'h6)
    `CHK(drive.regulator_enable, 1'b1)
    `CHK({drive.n_switch_gate_drive_o, drive.p_switch_gate_drive_oe}, 2'h1)
    print_verdict();
  end
endmodule : tb_wake_sequence_uv_retry
